// *** cmpc_cfg.svh ***
/*
 register offsets, field positions, reset values and timing counts of the
 comparator control block; included by the package users, defines only
*/
`ifndef CMPC_CFG_SVH
`define CMPC_CFG_SVH
// ==========================================================================
// register offsets
`define CMPC_OFS_MAIN 8'h00
`define CMPC_OFS_MUX 8'h02
`define CMPC_OFS_IRQEN 8'h06
`define CMPC_OFS_STATUS 8'h07
// ==========================================================================
// main control fields
`define CMPC_MAIN_ENABLE 0
`define CMPC_MAIN_HYS_LO 1
`define CMPC_MAIN_HYS_HI 2
`define CMPC_MAIN_LOWPWR 3
`define CMPC_MAIN_EDGE_LO 4
`define CMPC_MAIN_EDGE_HI 5
`define CMPC_MAIN_PADEN 6
`define CMPC_MAIN_STDBY 7
// ==========================================================================
// multiplexer control fields
`define CMPC_MUX_NEG_LO 0
`define CMPC_MUX_NEG_HI 1
`define CMPC_MUX_POS_LO 3
`define CMPC_MUX_POS_HI 4
`define CMPC_MUX_INVERT 7
// ==========================================================================
// interrupt and status fields
`define CMPC_IRQ_BIT 0
`define CMPC_STAT_STATE 4
// ==========================================================================
// reset values and writable masks
`define CMPC_RST_MAIN 8'h00
`define CMPC_RST_MUX 8'h00
`define CMPC_RST_IRQEN 8'h00
`define CMPC_MASK_MUX 8'h9B
`define CMPC_MASK_IRQEN 8'h01
// ==========================================================================
// synchroniser depth: state visible three cycles after the output moves
`define CMPC_SYNC_STAGES 3
`endif

// *** cmpc_pkg.sv ***
/*
 types of the comparator control block; constants live in cmpc_cfg.svh
*/
package cmpc_pkg;
	// edge selection codes for the interrupt flag
	typedef enum logic [1:0]
	{
		CMPC_EDGE_BOTH = 2'h0,
		CMPC_EDGE_RSVD = 2'h1,
		CMPC_EDGE_FALL = 2'h2,
		CMPC_EDGE_RISE = 2'h3
	} cmpc_edge_e;
	// controls toward the analog core
	typedef struct packed
	{
		logic enable;
		logic low_power_select;
		logic [1:0] hysteresis_level;
		logic [1:0] positive_input_select;
		logic [1:0] negative_input_select;
	} cmpc_analog_s;
	// register port request
	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} cmpc_bus_s;
endpackage : cmpc_pkg

// *** cmpc_sync.sv ***
/*
 multi-stage synchroniser for one level
 assumes: input asynchronous to clk_sys, rst synchronous active high
*/
`timescale 1ns/10ps
module cmpc_sync #(
	parameter int STAGES = 3
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic din,
	output logic dout
);
	logic [STAGES-1:0] chain;
	// ======================================================================
	// shift chain; only the next stage reads each flop
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			chain <= '0;
		else
			chain <= {chain[STAGES-2:0], din};
	end
	assign dout = chain[STAGES-1];
endmodule : cmpc_sync

// *** cmpc_regs.sv ***
/*
 digital control and status of an analog comparator: register file,
 analog core controls, output inversion, state synchroniser, edge flag,
 interrupt request, event and pad outputs.
 assumes: one clock clk_sys, synchronous active high rst, byte register port
 with read data one cycle after the read strobe; the analog core's raw output
 is asynchronous. standby gating of clk_sys is done outside this block.
*/
// Design decision made here: the strobed register port.
// Function
// - the two-bit hysteresis field at bits 2:1 drives the core's hysteresis control.
// - control bit 0 switches the comparator on while set and off while clear.
// - multiplexer bit 7 inverts the output for every consumer and the flag logic.
// - bits 4:3 pick positive pin n for code n.
// - bits 1:0 pick negative pin 0, pin 1, the reference or the converter output.
// - interrupt control bit 0 enables the comparator interrupt.
// - status bit 4 shows the output through a synchroniser, three cycles late.
// - status bit 0 is the flag, cleared by writing one, untouched by zero.
// - a two-bit field picks both edges, falling only or rising only (code 1 reserved).
// - the request is high, one cycle late, while the flag is set and the enable is one.
// - the pad carries the output only while the pad enable is set.
// - bit 7 is passed out as keep-running in standby; events and pad update only on clk_sys edges.
`timescale 1ns/10ps
`include "cmpc_cfg.svh"
module cmpc_regs (
	input wire logic clk_sys,
	input wire logic rst,
	input wire cmpc_pkg::cmpc_bus_s bus,
	output logic [7:0] rdata,
	input wire logic raw_out,
	output cmpc_pkg::cmpc_analog_s analog_ctrl,
	output logic keep_running_in_standby,
	output logic event_out,
	output logic pad_out,
	output logic pad_oe,
	output logic irq
);
	logic [7:0] main_ctrl;
	logic [7:0] mux_ctrl;
	logic [7:0] irq_en_ctrl;
	logic compare_irq_bit;
	logic state_sync;
	logic state_prev;
	logic edge_rise;
	logic edge_fall;
	logic edge_hit;
	logic clear_flag;
	logic raw_sync;
	logic [7:0] next_rdata;
	cmpc_pkg::cmpc_edge_e irq_edge_select;

	// ======================================================================
	// register writes
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			main_ctrl <= `CMPC_RST_MAIN;
		else if (bus.wr && bus.addr == `CMPC_OFS_MAIN)
			main_ctrl <= bus.wdata;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			mux_ctrl <= `CMPC_RST_MUX;
		else if (bus.wr && bus.addr == `CMPC_OFS_MUX)
			mux_ctrl <= bus.wdata & `CMPC_MASK_MUX;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			irq_en_ctrl <= `CMPC_RST_IRQEN;
		else if (bus.wr && bus.addr == `CMPC_OFS_IRQEN)
			irq_en_ctrl <= bus.wdata & `CMPC_MASK_IRQEN;
	end

	// ======================================================================
	// controls toward the analog core, all registered
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			analog_ctrl <= '0;
			keep_running_in_standby <= 1'b0;
		end
		else
		begin
			analog_ctrl.enable <= main_ctrl[`CMPC_MAIN_ENABLE];
			analog_ctrl.low_power_select <= main_ctrl[`CMPC_MAIN_LOWPWR];
			analog_ctrl.hysteresis_level <=
				main_ctrl[`CMPC_MAIN_HYS_HI:`CMPC_MAIN_HYS_LO];
			analog_ctrl.positive_input_select <=
				mux_ctrl[`CMPC_MUX_POS_HI:`CMPC_MUX_POS_LO];
			analog_ctrl.negative_input_select <=
				mux_ctrl[`CMPC_MUX_NEG_HI:`CMPC_MUX_NEG_LO];
			keep_running_in_standby <= main_ctrl[`CMPC_MAIN_STDBY];
		end
	end

	// ======================================================================
	// output inversion behind the synchroniser; pad and event one flop later
	assign state_sync = raw_sync ^ mux_ctrl[`CMPC_MUX_INVERT];
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			event_out <= 1'b0;
			pad_out <= 1'b0;
			pad_oe <= 1'b0;
		end
		else
		begin
			event_out <= state_sync & main_ctrl[`CMPC_MAIN_ENABLE];
			pad_out <= state_sync & main_ctrl[`CMPC_MAIN_ENABLE];
			pad_oe <= main_ctrl[`CMPC_MAIN_PADEN];
		end
	end

	// ======================================================================
	// synchroniser on the raw pin; no logic reads the pin ahead of it
	cmpc_sync #(
		.STAGES(`CMPC_SYNC_STAGES)
	) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.din(raw_out),
		.dout(raw_sync)
	);

	// ======================================================================
	// edge detection on the synchronised value
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			state_prev <= 1'b0;
		else
			state_prev <= state_sync;
	end

	assign irq_edge_select = cmpc_pkg::cmpc_edge_e'(main_ctrl[`CMPC_MAIN_EDGE_HI:`CMPC_MAIN_EDGE_LO]);
	assign edge_rise = state_sync & ~state_prev;
	assign edge_fall = ~state_sync & state_prev;

	// edge mode decode
	always_comb
	begin
		unique case (irq_edge_select)
			cmpc_pkg::CMPC_EDGE_BOTH: edge_hit = edge_rise | edge_fall;
			cmpc_pkg::CMPC_EDGE_RSVD: edge_hit = 1'b0;
			cmpc_pkg::CMPC_EDGE_FALL: edge_hit = edge_fall;
			cmpc_pkg::CMPC_EDGE_RISE: edge_hit = edge_rise;
		endcase
	end

	// ======================================================================
	// interrupt flag: write one clears, an edge in the same cycle wins
	assign clear_flag = bus.wr && bus.addr == `CMPC_OFS_STATUS && bus.wdata[`CMPC_IRQ_BIT];
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			compare_irq_bit <= 1'b0;
		else if (edge_hit && main_ctrl[`CMPC_MAIN_ENABLE])
			compare_irq_bit <= 1'b1;
		else if (clear_flag)
			compare_irq_bit <= 1'b0;
	end

	// level request
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= compare_irq_bit & irq_en_ctrl[`CMPC_IRQ_BIT];
	end

	// ======================================================================
	// read data, one cycle after the strobe; unmapped reads zero
	always_comb
	begin
		next_rdata = 8'h00;
		if (bus.rd)
		begin
			unique case (bus.addr)
				`CMPC_OFS_MAIN: next_rdata = main_ctrl;
				`CMPC_OFS_MUX: next_rdata = mux_ctrl;
				`CMPC_OFS_IRQEN: next_rdata = irq_en_ctrl;
				`CMPC_OFS_STATUS:
				begin
					next_rdata[`CMPC_STAT_STATE] = state_sync;
					next_rdata[`CMPC_IRQ_BIT] = compare_irq_bit;
				end
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rdata <= 8'h00;
		else
			rdata <= next_rdata;
	end

	// ======================================================================
	// checks
	sequence s_clear_write;
		bus.wr && bus.addr == `CMPC_OFS_STATUS && bus.wdata[`CMPC_IRQ_BIT];
	endsequence
	sequence s_no_edge;
		!(edge_hit && main_ctrl[`CMPC_MAIN_ENABLE]);
	endsequence

	AST_HYS: assert property (@(posedge clk_sys) disable iff (rst)
		analog_ctrl.hysteresis_level == $past(main_ctrl[2:1]))
		else $error("hysteresis control does not follow field");
	AST_ENABLE: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(main_ctrl[0]) |=> analog_ctrl.enable)
		else $error("enable not passed to core");
	AST_INVERT: assert property (@(posedge clk_sys) disable iff (rst)
		main_ctrl[`CMPC_MAIN_ENABLE]
		|=> event_out == ($past(raw_sync) ^ $past(mux_ctrl[`CMPC_MUX_INVERT])))
		else $error("event output not inverted as set");
	AST_POS: assert property (@(posedge clk_sys) disable iff (rst)
		analog_ctrl.positive_input_select == $past(mux_ctrl[4:3]))
		else $error("positive select wrong");
	AST_NEG: assert property (@(posedge clk_sys) disable iff (rst)
		analog_ctrl.negative_input_select == $past(mux_ctrl[1:0]))
		else $error("negative select wrong");
	AST_STATE: assert property (@(posedge clk_sys) disable iff (rst)
		$changed(raw_out) |-> ##2 raw_sync != $past(raw_out, 2)
		##1 raw_sync == $past(raw_out, 3))
		else $error("state not three cycles behind output");
	AST_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
		s_clear_write ##0 s_no_edge |=> !compare_irq_bit)
		else $error("flag not cleared by write of one");
	AST_RSVD: assert property (@(posedge clk_sys) disable iff (rst)
		irq_edge_select == cmpc_pkg::CMPC_EDGE_RSVD && !compare_irq_bit && !clear_flag
		|=> !compare_irq_bit)
		else $error("reserved edge mode set the flag");
	AST_IRQ: assert property (@(posedge clk_sys) disable iff (rst)
		irq == $past(compare_irq_bit & irq_en_ctrl[0]))
		else $error("request does not follow flag and enable");
	AST_PAD: assert property (@(posedge clk_sys) disable iff (rst)
		pad_oe |-> $past(main_ctrl[6]))
		else $error("pad driven without pad enable");
	AST_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		!main_ctrl[0] && !compare_irq_bit |=> !compare_irq_bit)
		else $error("flag set while comparator off");

	// ======================================================================
	// edge modes, judged on the state itself rather than on the decode
	sequence s_state_rise;
		!state_sync ##1 state_sync;
	endsequence
	sequence s_state_fall;
		state_sync ##1 !state_sync;
	endsequence
	sequence s_on_rise_mode;
		main_ctrl[`CMPC_MAIN_ENABLE] && irq_edge_select == cmpc_pkg::CMPC_EDGE_RISE;
	endsequence
	sequence s_on_fall_mode;
		main_ctrl[`CMPC_MAIN_ENABLE] && irq_edge_select == cmpc_pkg::CMPC_EDGE_FALL;
	endsequence
	sequence s_on_both_mode;
		main_ctrl[`CMPC_MAIN_ENABLE] && irq_edge_select == cmpc_pkg::CMPC_EDGE_BOTH;
	endsequence

	// matching edges set the flag one cycle later
	AST_RISE_SET: assert property (@(posedge clk_sys) disable iff (rst)
		s_state_rise ##0 s_on_rise_mode |=> compare_irq_bit)
		else $error("rising edge did not set the flag");
	AST_FALL_SET: assert property (@(posedge clk_sys) disable iff (rst)
		s_state_fall ##0 s_on_fall_mode |=> compare_irq_bit)
		else $error("falling edge did not set the flag");
	AST_BOTH_SET: assert property (@(posedge clk_sys) disable iff (rst)
		$changed(state_sync) ##0 s_on_both_mode |=> compare_irq_bit)
		else $error("edge in both-edge mode did not set the flag");

	// the opposite edge leaves a clear flag alone
	AST_RISE_ONLY: assert property (@(posedge clk_sys) disable iff (rst)
		s_state_fall ##0 s_on_rise_mode ##0 !compare_irq_bit ##0 !clear_flag
		|=> !compare_irq_bit)
		else $error("falling edge set the flag in rising mode");
	AST_FALL_ONLY: assert property (@(posedge clk_sys) disable iff (rst)
		s_state_rise ##0 s_on_fall_mode ##0 !compare_irq_bit ##0 !clear_flag
		|=> !compare_irq_bit)
		else $error("rising edge set the flag in falling mode");

	// clearing: a new edge beats the clear, a written zero does nothing
	AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (rst)
		s_clear_write ##0 (edge_hit && main_ctrl[`CMPC_MAIN_ENABLE]) |=> compare_irq_bit)
		else $error("clear write beat a new edge");
	AST_WRITE_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
		bus.wr && bus.addr == `CMPC_OFS_STATUS && !bus.wdata[`CMPC_IRQ_BIT] && compare_irq_bit
		|=> compare_irq_bit)
		else $error("write of zero cleared the flag");

	// register effects and outputs while off
	AST_IRQEN: assert property (@(posedge clk_sys) disable iff (rst)
		bus.wr && bus.addr == `CMPC_OFS_IRQEN
		|=> irq_en_ctrl == {7'h00, $past(bus.wdata[`CMPC_IRQ_BIT])})
		else $error("interrupt enable not taken from write");
	AST_DARK: assert property (@(posedge clk_sys) disable iff (rst)
		!main_ctrl[`CMPC_MAIN_ENABLE] |=> !event_out && !pad_out)
		else $error("event or pad active while comparator off");
	AST_STDBY: assert property (@(posedge clk_sys) disable iff (rst)
		keep_running_in_standby == $past(main_ctrl[`CMPC_MAIN_STDBY]))
		else $error("keep-running control does not follow its bit");
endmodule : cmpc_regs

// *** tb_top.sv ***
/*
 self-checking bench of the comparator control block: register access,
 analog controls, inversion, edge modes, flag clear and interrupt masking.
 assumes: cmpc_pkg compiled first, cmpc_cfg.svh on the include path.
*/
`timescale 1ns/10ps
`include "cmpc_cfg.svh"
module tb_top;
	// ==========================================================================
	// clock, reset and stimulus signals
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	cmpc_pkg::cmpc_bus_s bus = '0;
	logic raw_out = 1'b0;
	logic [7:0] rdata;
	cmpc_pkg::cmpc_analog_s analog_ctrl;
	logic keep_running_in_standby;
	logic event_out;
	logic pad_out;
	logic pad_oe;
	logic irq;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [7:0] v;
	logic [1:0] m;
	logic rf;
	logic ff;
	// 25 MHz clock
	always #20 clk_sys = ~clk_sys;
	// ==========================================================================
	// device under test
	cmpc_regs DUT (
		.clk_sys(clk_sys),
		.rst(rst),
		.bus(bus),
		.rdata(rdata),
		.raw_out(raw_out),
		.analog_ctrl(analog_ctrl),
		.keep_running_in_standby(keep_running_in_standby),
		.event_out(event_out),
		.pad_out(pad_out),
		.pad_oe(pad_oe),
		.irq(irq)
	);
	// ==========================================================================
	// verdict and end of run
	task automatic report_and_stop;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	// hang guard: the whole sequence needs well under this many cycles
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			n_mismatch = n_mismatch + 1;
			report_and_stop();
		end
	end
	// ==========================================================================
	// bus and comparison tasks
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	// one-cycle write strobe, then one idle cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus <= '0;
		@(posedge clk_sys);
	endtask : wr
	// one-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus <= '0;
		#1 d = rdata;
		@(posedge clk_sys);
	endtask : rd
	task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(name, d, exp);
	endtask : rdchk
	// move the raw output and let it cross the synchroniser and flag logic
	task automatic drive_raw(input logic b);
		raw_out <= b;
		tick(8);
	endtask : drive_raw
	// ==========================================================================
	// main sequence
	initial
	begin
		tick(2);
		rst <= 1'b0;
		@(posedge clk_sys);
		// reset values, unmapped address reads zero
		rdchk("main", `CMPC_OFS_MAIN, 8'h00);
		rdchk("mux", `CMPC_OFS_MUX, 8'h00);
		rdchk("irqen", `CMPC_OFS_IRQEN, 8'h00);
		rdchk("status", `CMPC_OFS_STATUS, 8'h00);
		wr(8'h01, 8'hFF);
		rdchk("unmapped", 8'h01, 8'h00);
		// access kinds and reserved bits
		wr(`CMPC_OFS_MUX, 8'hFF);
		rdchk("mux mask", `CMPC_OFS_MUX, 8'h9B);
		wr(`CMPC_OFS_IRQEN, 8'hFF);
		rdchk("irqen mask", `CMPC_OFS_IRQEN, 8'h01);
		wr(`CMPC_OFS_MAIN, 8'hC8);
		rdchk("main rw", `CMPC_OFS_MAIN, 8'hC8);
		chk("low power", {7'h00, analog_ctrl.low_power_select}, 8'h01);
		chk("pad enable", {7'h00, pad_oe}, 8'h01);
		chk("standby", {7'h00, keep_running_in_standby}, 8'h01);
		wr(`CMPC_OFS_MUX, 8'h00);
		// hysteresis, positive and negative selections, enable
		for (int i = 0; i < 4; i++)
		begin
			m = i[1:0];
			wr(`CMPC_OFS_MAIN, {5'h00, m, 1'b1});
			wr(`CMPC_OFS_MUX, {3'h0, m, 1'b0, ~m});
			tick(1);
			chk("analog", analog_ctrl, {1'b1, 1'b0, m, m, ~m});
		end
		wr(`CMPC_OFS_MAIN, 8'h00);
		tick(1);
		chk("disabled", {7'h00, analog_ctrl.enable}, 8'h00);
		wr(`CMPC_OFS_MUX, 8'h00);
		wr(`CMPC_OFS_STATUS, 8'h01);
		// every edge mode, both edges, flag clear by one only
		for (int i = 0; i < 4; i++)
		begin
			m = (i == 3) ? 2'h1 : ((i == 0) ? 2'h0 : i[1:0] + 2'h1);
			rf = (m == 2'h0) || (m == 2'h3);
			ff = (m == 2'h0) || (m == 2'h2);
			wr(`CMPC_OFS_MAIN, {2'b01, m, 4'h1});
			wr(`CMPC_OFS_STATUS, 8'h01);
			rdchk("cleared", `CMPC_OFS_STATUS, 8'h00);
			drive_raw(1'b1);
			rdchk("rise", `CMPC_OFS_STATUS, {7'h08, rf});
			chk("irq rise", {7'h00, irq}, {7'h00, rf});
			chk("event", {6'h00, event_out, pad_out}, 8'h03);
			wr(`CMPC_OFS_STATUS, 8'h00);
			rdchk("write zero", `CMPC_OFS_STATUS, {7'h08, rf});
			wr(`CMPC_OFS_STATUS, 8'h01);
			rdchk("write one", `CMPC_OFS_STATUS, 8'h10);
			chk("irq clear", {7'h00, irq}, 8'h00);
			drive_raw(1'b0);
			rdchk("fall", `CMPC_OFS_STATUS, {7'h00, ff});
		end
		// inversion reaches state, flag, event and pad
		wr(`CMPC_OFS_MAIN, 8'h41);
		wr(`CMPC_OFS_STATUS, 8'h01);
		wr(`CMPC_OFS_MUX, 8'h80);
		tick(6);
		rdchk("inverted", `CMPC_OFS_STATUS, 8'h11);
		chk("inv event", {6'h00, event_out, pad_out}, 8'h03);
		// interrupt masked, then unmasked with the flag still set
		wr(`CMPC_OFS_IRQEN, 8'h00);
		tick(1);
		chk("irq masked", {7'h00, irq}, 8'h00);
		wr(`CMPC_OFS_IRQEN, 8'h01);
		tick(1);
		chk("irq unmasked", {7'h00, irq}, 8'h01);
		// an edge in the same cycle as a clear write keeps the flag set
		wr(`CMPC_OFS_STATUS, 8'h01);
		raw_out <= 1'b1;
		tick(3);
		wr(`CMPC_OFS_STATUS, 8'h01);
		rdchk("set wins", `CMPC_OFS_STATUS, 8'h01);
		// no edges seen while disabled, outputs held low
		wr(`CMPC_OFS_MAIN, 8'h00);
		wr(`CMPC_OFS_STATUS, 8'h01);
		drive_raw(1'b1);
		drive_raw(1'b0);
		rd(`CMPC_OFS_STATUS, v);
		chk("no flag off", v & 8'h01, 8'h00);
		chk("event off", {6'h00, event_out, pad_out}, 8'h00);
		chk("irq off", {7'h00, irq}, 8'h00);
		report_and_stop();
	end
endmodule : tb_top
